/* ads_pkg.sv */
package ads_pkg;

	// ==========================================================
	// widths
	localparam int SEG_W = 8;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int IDX_W = 8;
	localparam int IRQ_W = 3;

	// ==========================================================
	// register indices, byte address is index times four
	localparam logic [7:0] IDX_CALIB_RESULT = 8'h25;
	localparam logic [7:0] IDX_AM_LEVEL = 8'h26;
	localparam logic [7:0] IDX_NORM_LEVEL = 8'h27;
	localparam logic [7:0] IDX_CONTROL = 8'h30;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h31;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h32;

	// ==========================================================
	// reset values and special patterns
	localparam logic [7:0] RST_CALIB_RESULT = 8'h00;
	localparam logic [7:0] RST_LEVEL = 8'h00;
	localparam logic [7:0] SEG_ALL_OFF = 8'hff;
	localparam logic [2:0] RST_IRQ = 3'h0;

	// ==========================================================
	// field positions
	localparam int CTRL_AM_SRC_BIT = 0;
	localparam int CTRL_RESTORE_BIT = 1;
	localparam int IRQ_CALIB_DONE = 0;
	localparam int IRQ_CALIB_ERR = 1;
	localparam int IRQ_RESTORED = 2;

	// ==========================================================
	// bus handshake states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} ads_bus_state_t;

endpackage : ads_pkg

/* ads_bus_slave.sv */
`timescale 1ns/1ps
module ads_bus_slave (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// avalon-mm slave
	input wire logic [ads_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [ads_pkg::DATA_W-1:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [ads_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	// register file side
	output logic [ads_pkg::IDX_W-1:0] regIndex,
	output logic regWrite,
	output logic [ads_pkg::SEG_W-1:0] regWdata,
	input wire logic [ads_pkg::SEG_W-1:0] regReadData
);

	// ==========================================================
	// state
	typedef struct packed {
		ads_pkg::ads_bus_state_t st;
		logic waitReq;
		logic [ads_pkg::DATA_W-1:0] rdata;
	} ads_bus_t;

	ads_bus_t bus_ff;
	ads_bus_t nxt_bus;

	// ==========================================================
	// one wait state; write lands on the completing edge
	always_comb begin
		nxt_bus = bus_ff;
		regWrite = 1'b0;
		case (bus_ff.st)
			ads_pkg::BUS_IDLE: begin
				if (read || write) begin
					nxt_bus.st = ads_pkg::BUS_ANSWER;
					nxt_bus.waitReq = 1'b0;
					nxt_bus.rdata = read ? {24'h000000, regReadData} : 32'h00000000;
				end
			end
			ads_pkg::BUS_ANSWER: begin
				// only lane 0 carries register bits
				regWrite = write && byteenable[0];
				nxt_bus.st = ads_pkg::BUS_IDLE;
				nxt_bus.waitReq = 1'b1;
			end
			default: begin
				nxt_bus.st = ads_pkg::BUS_IDLE;
				nxt_bus.waitReq = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bus_ff.st <= ads_pkg::BUS_IDLE;
			bus_ff.waitReq <= 1'b1;
			bus_ff.rdata <= 32'h00000000;
		end else begin
			bus_ff <= nxt_bus;
		end
	end

	assign regIndex = address[ads_pkg::ADDR_W-1:2];
	assign regWdata = writedata[ads_pkg::SEG_W-1:0];
	assign readdata = bus_ff.rdata;
	assign waitrequest = bus_ff.waitReq;

endmodule : ads_bus_slave

/* ads_segment_select.sv */
`timescale 1ns/1ps
module ads_segment_select #(
	parameter int SegW = ads_pkg::SEG_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// patterns and modulation state
	input wire logic modState,
	input wire logic [SegW-1:0] normPattern,
	input wire logic [SegW-1:0] modPattern,
	input wire logic restore,
	// driver stage
	output logic [SegW-1:0] segDisable,
	output logic tristate
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [SegW-1:0] seg;
		logic tri3;
	} ads_sel_t;

	ads_sel_t sel_ff;
	ads_sel_t nxt_sel;

	// one register stage: all bits swap on one edge, no mixed pattern
	always_comb begin
		nxt_sel = sel_ff;
		nxt_sel.seg = modState ? modPattern : normPattern;
		nxt_sel.tri3 = !modState && (normPattern == {SegW{1'b1}});
		if (restore) begin
			nxt_sel.seg = {SegW{1'b0}};
			nxt_sel.tri3 = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sel_ff.seg <= {SegW{1'b0}};
			sel_ff.tri3 <= 1'b0;
		end else begin
			sel_ff <= nxt_sel;
		end
	end

	assign segDisable = sel_ff.seg;
	assign tristate = sel_ff.tri3;

endmodule : ads_segment_select

/* ads_segment_ctrl.sv */
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
// What this block does
// - calibration command loads result register with segments to disable when modulated
// - failed calibration writes all ones into the result register
// - result register clears at reset and on restore-defaults
// - manual source: set bits of modulated-level register disable segments when modulated
// - set bits of normal-level register disable segments during normal transmission
// - eight binary-weighted segments, one control bit each per register
// - bit 7 drives the strongest segment, bit 0 the weakest
// - normal-level register all ones puts the drivers in tristate during normal transmission, not when modulated
// - both level registers clear at reset and on restore-defaults
// - source select picks manual level or calibrated level for modulation
module ads_segment_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// avalon-mm slave
	input wire logic [ads_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [ads_pkg::DATA_W-1:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [ads_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	// calibration engine and commands
	input wire logic calibDone,
	input wire logic calibFail,
	input wire logic [ads_pkg::SEG_W-1:0] calibSegmentFlag,
	input wire logic restoreDefaults,
	// transmitter
	input wire logic modState,
	output logic [ads_pkg::SEG_W-1:0] antennaDriverOutputOff,
	output logic antennaDriverOutputTristate,
	// interrupt
	output logic irq
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [ads_pkg::SEG_W-1:0] calibResult;
		logic [ads_pkg::SEG_W-1:0] amLevel;
		logic [ads_pkg::SEG_W-1:0] normLevel;
		logic amLevelSourceSelect;
		logic [ads_pkg::IRQ_W-1:0] irqStatus;
		logic [ads_pkg::IRQ_W-1:0] irqMask;
		logic irq;
	} ads_ctrl_t;

	ads_ctrl_t s_ff;
	ads_ctrl_t nxt_s;

	logic [ads_pkg::IDX_W-1:0] regIndex;
	logic regWrite;
	logic [ads_pkg::SEG_W-1:0] regWdata;
	logic [ads_pkg::SEG_W-1:0] regReadData;
	logic restore;
	logic [ads_pkg::IRQ_W-1:0] events;
	logic [ads_pkg::SEG_W-1:0] modPattern;

	// ==========================================================
	// bus slave
	ads_bus_slave u_bus (
		.clk(clk),
		.rst_b(rst_b),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(byteenable),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.regIndex(regIndex),
		.regWrite(regWrite),
		.regWdata(regWdata),
		.regReadData(regReadData)
	);

	// ==========================================================
	// commands and events
	assign restore = restoreDefaults ||
		(regWrite && regIndex == ads_pkg::IDX_CONTROL &&
		regWdata[ads_pkg::CTRL_RESTORE_BIT]);

	always_comb begin
		events = ads_pkg::RST_IRQ;
		events[ads_pkg::IRQ_CALIB_DONE] = calibDone && !calibFail;
		events[ads_pkg::IRQ_CALIB_ERR] = calibDone && calibFail;
		events[ads_pkg::IRQ_RESTORED] = restore;
	end

	// ==========================================================
	// register file
	always_comb begin
		nxt_s = s_ff;
		if (regWrite) begin
			case (regIndex)
				ads_pkg::IDX_AM_LEVEL: nxt_s.amLevel = regWdata;
				ads_pkg::IDX_NORM_LEVEL: nxt_s.normLevel = regWdata;
				ads_pkg::IDX_CONTROL: begin
					nxt_s.amLevelSourceSelect =
						regWdata[ads_pkg::CTRL_AM_SRC_BIT];
				end
				ads_pkg::IDX_IRQ_STATUS: begin
					nxt_s.irqStatus = s_ff.irqStatus &
						~regWdata[ads_pkg::IRQ_W-1:0];
				end
				ads_pkg::IDX_IRQ_MASK: nxt_s.irqMask = regWdata[ads_pkg::IRQ_W-1:0];
				// result register is not writable by software
				ads_pkg::IDX_CALIB_RESULT: nxt_s.calibResult = s_ff.calibResult;
				default: nxt_s = nxt_s;
			endcase
		end
		if (calibDone) begin
			// a failed run reports every segment as off
			nxt_s.calibResult = calibFail ? ads_pkg::SEG_ALL_OFF :
				calibSegmentFlag;
		end
		// restore-defaults beats a calibration finishing in the same cycle
		if (restore) begin
			nxt_s.calibResult = ads_pkg::RST_CALIB_RESULT;
			nxt_s.amLevel = ads_pkg::RST_LEVEL;
			nxt_s.normLevel = ads_pkg::RST_LEVEL;
			nxt_s.amLevelSourceSelect = 1'b0;
		end
		// set beats clear so no event is lost
		nxt_s.irqStatus = nxt_s.irqStatus | events;
		nxt_s.irq = |(nxt_s.irqStatus & nxt_s.irqMask);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_ff.calibResult <= ads_pkg::RST_CALIB_RESULT;
			s_ff.amLevel <= ads_pkg::RST_LEVEL;
			s_ff.normLevel <= ads_pkg::RST_LEVEL;
			s_ff.amLevelSourceSelect <= 1'b0;
			s_ff.irqStatus <= ads_pkg::RST_IRQ;
			s_ff.irqMask <= ads_pkg::RST_IRQ;
			s_ff.irq <= 1'b0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ==========================================================
	// read mux, unmapped reads return zero
	always_comb begin
		regReadData = 8'h00;
		case (regIndex)
			ads_pkg::IDX_CALIB_RESULT: regReadData = s_ff.calibResult;
			ads_pkg::IDX_AM_LEVEL: regReadData = s_ff.amLevel;
			ads_pkg::IDX_NORM_LEVEL: regReadData = s_ff.normLevel;
			ads_pkg::IDX_CONTROL: begin
				regReadData[ads_pkg::CTRL_AM_SRC_BIT] = s_ff.amLevelSourceSelect;
			end
			ads_pkg::IDX_IRQ_STATUS: regReadData[ads_pkg::IRQ_W-1:0] = s_ff.irqStatus;
			ads_pkg::IDX_IRQ_MASK: regReadData[ads_pkg::IRQ_W-1:0] = s_ff.irqMask;
			default: regReadData = 8'h00;
		endcase
	end

	// ==========================================================
	// segment drive; bit n maps straight to segment n, bit 7 strongest
	// automatic source uses the calibrated result pattern
	assign modPattern = s_ff.amLevelSourceSelect ? s_ff.amLevel :
		s_ff.calibResult;

	ads_segment_select #(
		.SegW(ads_pkg::SEG_W)
	) u_sel (
		.clk(clk),
		.rst_b(rst_b),
		.modState(modState),
		.normPattern(s_ff.normLevel),
		.modPattern(modPattern),
		.restore(restore),
		.segDisable(antennaDriverOutputOff),
		.tristate(antennaDriverOutputTristate)
	);

	assign irq = s_ff.irq;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_calib_load: assert property (
		calibDone && !calibFail && !restore |=>
		s_ff.calibResult == $past(calibSegmentFlag))
		else $error("calibration pattern not loaded");

	a_calib_error: assert property (
		calibDone && calibFail && !restore |=> s_ff.calibResult == 8'hff)
		else $error("calibration error not all ones");

	a_calib_restore: assert property (
		restore |=> s_ff.calibResult == 8'h00)
		else $error("result not cleared by restore");

	a_am_manual: assert property (
		s_ff.amLevelSourceSelect && modState && !restore |=>
		antennaDriverOutputOff == $past(s_ff.amLevel))
		else $error("manual modulated pattern not driven");

	a_normal_level: assert property (
		!modState && !restore ##1 !modState && !restore |=>
		antennaDriverOutputOff == $past(s_ff.normLevel))
		else $error("normal pattern not driven");

	a_tristate_full: assert property (
		!modState && s_ff.normLevel == 8'hff && !restore |=>
		antennaDriverOutputTristate && antennaDriverOutputOff == 8'hff)
		else $error("all ones did not tristate drivers");

	a_level_restore: assert property (
		restore |=> s_ff.amLevel == 8'h00 && s_ff.normLevel == 8'h00)
		else $error("level registers not cleared");

	a_auto_source: assert property (
		!s_ff.amLevelSourceSelect && modState && !restore |=>
		antennaDriverOutputOff == $past(s_ff.calibResult))
		else $error("calibrated pattern not used");

	a_result_ro: assert property (
		regWrite && regIndex == ads_pkg::IDX_CALIB_RESULT &&
		!calibDone && !restore |=> $stable(s_ff.calibResult))
		else $error("software changed result register");

	a_switch_clean: assert property (
		$changed(modState) && !restore |=>
		antennaDriverOutputOff ==
		($past(modState) ? $past(modPattern) : $past(s_ff.normLevel)))
		else $error("intermediate segment pattern");

	a_irq_level: assert property (
		irq == |(s_ff.irqStatus & s_ff.irqMask))
		else $error("interrupt does not follow status");

	// ==========================================================
	// register and bus checks
	a_norm_write: assert property (
		regWrite && regIndex == ads_pkg::IDX_NORM_LEVEL && !restore |=>
		s_ff.normLevel == $past(regWdata))
		else $error("normal level write lost");

	a_am_write: assert property (
		regWrite && regIndex == ads_pkg::IDX_AM_LEVEL && !restore |=>
		s_ff.amLevel == $past(regWdata))
		else $error("modulated level write lost");

	a_level_hold: assert property (
		!regWrite && !restore |=>
		$stable(s_ff.normLevel) && $stable(s_ff.amLevel))
		else $error("level register changed on its own");

	a_src_write: assert property (
		regWrite && regIndex == ads_pkg::IDX_CONTROL && !restore |=>
		{7'h00, s_ff.amLevelSourceSelect} == ($past(regWdata) & 8'h01))
		else $error("source select write lost");

	a_src_restore: assert property (
		restore |=> !s_ff.amLevelSourceSelect)
		else $error("source select not cleared by restore");

	a_calib_hold: assert property (
		!calibDone && !restore |=> $stable(s_ff.calibResult))
		else $error("result changed without calibration");

	a_restore_pins: assert property (
		restore |=>
		antennaDriverOutputOff == 8'h00 && !antennaDriverOutputTristate)
		else $error("segments not enabled by restore");

	a_mod_no_tri: assert property (
		modState && !restore |=> !antennaDriverOutputTristate)
		else $error("tristate while modulated");

	a_tri_pattern: assert property (
		antennaDriverOutputTristate |->
		antennaDriverOutputOff == 8'hff)
		else $error("tristate with segments enabled");

	a_bus_answer: assert property (
		(read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered");

	a_wait_one: assert property (
		!waitrequest |=> waitrequest)
		else $error("wait request low too long");

	a_read_data: assert property (
		read && waitrequest |=>
		readdata == {24'h000000, $past(regReadData)})
		else $error("read data not captured");

	a_read_upper: assert property (
		readdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");

	a_lane_ignore: assert property (
		!waitrequest && write && !byteenable[0] && !restoreDefaults |=>
		$stable(s_ff.normLevel) && $stable(s_ff.amLevel))
		else $error("write without lane 0 accepted");

	// ==========================================================
	// interrupt checks
	a_status_ok: assert property (
		calibDone && !calibFail |=>
		s_ff.irqStatus[ads_pkg::IRQ_CALIB_DONE])
		else $error("calibration done not flagged");

	a_status_err: assert property (
		calibDone && calibFail |=>
		s_ff.irqStatus[ads_pkg::IRQ_CALIB_ERR])
		else $error("calibration error not flagged");

	a_status_restore: assert property (
		restore |=> s_ff.irqStatus[ads_pkg::IRQ_RESTORED])
		else $error("restore not flagged");

	a_status_clear: assert property (
		regWrite && regIndex == ads_pkg::IDX_IRQ_STATUS &&
		regWdata[ads_pkg::IRQ_CALIB_DONE] && !calibDone |=>
		!s_ff.irqStatus[ads_pkg::IRQ_CALIB_DONE])
		else $error("status bit not cleared");

	a_status_sticky: assert property (
		s_ff.irqStatus[ads_pkg::IRQ_CALIB_ERR] && !(regWrite &&
		regIndex == ads_pkg::IDX_IRQ_STATUS) |=>
		s_ff.irqStatus[ads_pkg::IRQ_CALIB_ERR])
		else $error("status bit lost");

	a_mask_write: assert property (
		regWrite && regIndex == ads_pkg::IDX_IRQ_MASK |=>
		{5'h00, s_ff.irqMask} == ($past(regWdata) & 8'h07))
		else $error("mask write lost");

	// ==========================================================
	// scenarios
	c_calib_fail: cover property (calibDone && calibFail);
	c_manual_mod: cover property (s_ff.amLevelSourceSelect && modState);
	c_tristate: cover property (antennaDriverOutputTristate);
	c_irq: cover property (irq ##1 !irq);
	c_restore: cover property (restore);

endmodule : ads_segment_ctrl

/* ads_driver_model.sv */
`timescale 1ns/1ps
module ads_driver_model (
	// driver stage controls
	input wire logic [ads_pkg::SEG_W-1:0] segOff,
	input wire logic tristate,
	// legs really driving the antenna
	output logic [ads_pkg::SEG_W-1:0] segOn
);
	// ==========================================================
	// driver legs
	// bit 7 is the 2 ohm leg, bit 0 the 256 ohm leg
	// tristate floats every leg, whatever the pattern says
	assign segOn = tristate ? '0 : ~segOff;
endmodule : ads_driver_model

/* tb_antenna_driver_segment_control.sv */
`timescale 1ns/1ps
module tb_antenna_driver_segment_control;
	// ==========================================================
	// signals
	logic clk, rst_b, read, write, calibDone, calibFail, restoreDefaults;
	logic modState, irq, waitrequest, tri_s;
	logic [9:0] address;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable;
	logic [7:0] calibSegmentFlag, offPins, segOn, rd;
	int fails = 0;
	int checks = 0;

	ads_segment_ctrl uut (.clk(clk), .rst_b(rst_b), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .calibDone(calibDone),
		.calibFail(calibFail), .calibSegmentFlag(calibSegmentFlag),
		.restoreDefaults(restoreDefaults), .modState(modState),
		.antennaDriverOutputOff(offPins),
		.antennaDriverOutputTristate(tri_s), .irq(irq));
	ads_driver_model drv (.segOff(offPins), .tristate(tri_s), .segOn(segOn));

	// ==========================================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		// whole run is well under 2000 cycles
		#100000;
		fails++;
		report_and_stop();
	end

	// ==========================================================
	// tasks
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] idx,
			input logic [7:0] d, input logic [3:0] be, output logic [7:0] q);
		@(posedge clk);
		address <= {idx, 2'b00};
		read <= ~wr;
		write <= wr;
		writedata <= {24'h000000, d};
		byteenable <= be;
		// no cycle count assumed; a hung slave is left to the watchdog
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, idx, d, 4'hf, q);
	endtask : wr
	task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, idx, 8'h00, 4'hf, q);
		chk(nm, e, q);
	endtask : rchk
	task automatic settle();
		// pins follow a write one edge later; read at the third edge,
		// before it updates, so new stimulus still lands on an edge
		repeat (3) @(posedge clk);
	endtask : settle
	task automatic calib(input logic f, input logic [7:0] p);
		@(posedge clk);
		calibDone <= 1'b1;
		calibFail <= f;
		calibSegmentFlag <= p;
		@(posedge clk);
		calibDone <= 1'b0;
	endtask : calib
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// tests
	initial begin
		rst_b = 1'b0; read = 1'b0; write = 1'b0; address = 10'h000;
		writedata = 32'h00000000; byteenable = 4'hf; calibDone = 1'b0;
		calibFail = 1'b0; calibSegmentFlag = 8'h00; restoreDefaults = 1'b0;
		modState = 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		rchk("result", 8'h25, 8'h00);
		rchk("amLevel", 8'h26, 8'h00);
		rchk("normLevel", 8'h27, 8'h00);
		settle();
		chk("offPins", 8'h00, offPins);
		$display("test reset done");
		wr(8'h27, 8'hc0);
		settle();
		chk("offPins", 8'hc0, offPins);
		chk("segOn", 8'h3f, segOn);
		bus(1'b1, 8'h27, 8'hff, 4'he, rd);
		rchk("normLevel", 8'h27, 8'hc0);
		wr(8'h27, 8'hff);
		settle();
		chk("tristate", 8'h01, {7'h00, tri_s});
		chk("segOn", 8'h00, segOn);
		wr(8'h27, 8'h03);
		settle();
		chk("segOn", 8'hfc, segOn);
		$display("test normal done");
		wr(8'h26, 8'ha5);
		wr(8'h30, 8'h01);
		modState <= 1'b1;
		settle();
		chk("offPins", 8'ha5, offPins);
		chk("tristate", 8'h00, {7'h00, tri_s});
		modState <= 1'b0;
		settle();
		chk("offPins", 8'h03, offPins);
		$display("test manual done");
		wr(8'h30, 8'h00);
		calib(1'b0, 8'h3c);
		rchk("result", 8'h25, 8'h3c);
		modState <= 1'b1;
		settle();
		chk("offPins", 8'h3c, offPins);
		modState <= 1'b0;
		wr(8'h25, 8'h77);
		rchk("result", 8'h25, 8'h3c);
		rchk("unmapped", 8'h3f, 8'h00);
		calib(1'b1, 8'h12);
		rchk("result", 8'h25, 8'hff);
		$display("test calibration done");
		wr(8'h32, 8'h01);
		calib(1'b0, 8'h3c);
		settle();
		chk("irq", 8'h01, {7'h00, irq});
		rchk("status", 8'h31, 8'h03);
		wr(8'h31, 8'h01);
		settle();
		chk("irq", 8'h00, {7'h00, irq});
		rchk("status", 8'h31, 8'h02);
		$display("test interrupt done");
		wr(8'h26, 8'h11);
		wr(8'h30, 8'h02);
		rchk("result", 8'h25, 8'h00);
		rchk("amLevel", 8'h26, 8'h00);
		rchk("normLevel", 8'h27, 8'h00);
		rchk("status", 8'h31, 8'h06);
		settle();
		chk("offPins", 8'h00, offPins);
		chk("irq", 8'h00, {7'h00, irq});
		wr(8'h27, 8'h81);
		calib(1'b0, 8'h44);
		@(posedge clk);
		restoreDefaults <= 1'b1;
		@(posedge clk);
		restoreDefaults <= 1'b0;
		rchk("normLevel", 8'h27, 8'h00);
		rchk("result", 8'h25, 8'h00);
		$display("test restore done");
		wr(8'h26, 8'h5a);
		wr(8'h27, 8'h18);
		calib(1'b0, 8'h42);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rchk("result", 8'h25, 8'h00);
		rchk("amLevel", 8'h26, 8'h00);
		rchk("normLevel", 8'h27, 8'h00);
		rchk("status", 8'h31, 8'h00);
		settle();
		chk("offPins", 8'h00, offPins);
		chk("irq", 8'h00, {7'h00, irq});
		$display("test reset again done");
		report_and_stop();
	end
endmodule : tb_antenna_driver_segment_control
